/* hw/vst_pkg.sv */
// package: constants, register map and record types for the table block
package vst_pkg;

  localparam int PORTS   = 11;
  localparam int VID_W   = 12;
  localparam int VLAN_N  = 4096;
  localparam int SVC_W   = 8;
  localparam int SVC_N   = 256;
  localparam int SPAN_W  = 6;
  localparam int POL_W   = 8;
  localparam int PROF_W  = 4;
  localparam int PROF_N  = 16;
  localparam int PORT_W  = 4;
  localparam int CMD_W   = 2;
  localparam int ADDR_W  = 12;

  typedef enum logic [CMD_W-1:0] {
    VST_CMD_IDLE  = 2'h0,
    VST_CMD_READ  = 2'h1,
    VST_CMD_WRITE = 2'h2,
    VST_CMD_INIT  = 2'h3
  } vst_cmd_t;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_VLAN_IDX = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_VLAN_ACC = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SVC_IDX  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SVC_ACC  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_DOMAIN   = 12'h010;

  // field positions
  localparam int VIDX_LSB  = 0;
  localparam int VMIR_BIT  = 12;
  localparam int VFILT_BIT = 13;
  localparam int VNOLR_BIT = 14;
  localparam int VPRIV_BIT = 15;
  localparam int CMD_LSB   = 0;
  localparam int MASK_LSB  = 2;
  localparam int SIDX_LSB  = 0;
  localparam int SSPAN_LSB = 8;
  localparam int SKEY_BIT  = 14;
  localparam int SPOL_LSB  = 15;

  localparam logic [PORTS-1:0] MASK_ALL = 11'h7ff;

  typedef struct packed {
    logic [PORTS-1:0] members;
    logic             mirror;
    logic             filt;
    logic             no_learn;
    logic             priv;
  } vst_vlan_t;

  typedef struct packed {
    logic [PORTS-1:0]  dest;
    logic [SPAN_W-1:0] span;
    logic              key;
    logic [POL_W-1:0]  pol;
  } vst_svc_t;

  localparam vst_vlan_t VLAN_DEF = '{MASK_ALL, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam vst_svc_t  SVC_DEF  = '{MASK_ALL, 6'h00, 1'b0, 8'h00};

endpackage

/* hw/vst_tbl_if.sv */
// interface: command handshake between register file and table sequencer
`timescale 1ns/10ps
`default_nettype none
interface vst_tbl_if #(parameter int AW = 8);
  logic              start;
  vst_pkg::vst_cmd_t cmd;
  logic [AW-1:0]     idx;
  logic              busy;
  logic              wr_en;
  logic              rd_en;
  logic              init_en;
  logic              done;
  logic [AW-1:0]     addr;
  modport seq (input start, cmd, idx,
               output busy, wr_en, rd_en, init_en, done, addr);
  modport user (output start, cmd, idx,
                input busy, wr_en, rd_en, init_en, done, addr);
endinterface
`default_nettype wire

/* hw/vst_tbl_seq.sv */
// table command sequencer: single access or walk of all entries for init
`timescale 1ns/10ps
`default_nettype none
module vst_tbl_seq #(parameter int AW = 8) (
  input  wire logic clk,
  input  wire logic rst,
  vst_tbl_if.seq    t
);

  typedef enum logic [1:0] {
    VST_S_IDLE = 2'b00,
    VST_S_ACC  = 2'b01,
    VST_S_INIT = 2'b10
  } vst_state_t;

  localparam logic [AW-1:0] LAST = '1;
  localparam logic [AW-1:0] ZERO = '0;

  vst_state_t        state_q;
  vst_state_t        state_d;
  vst_pkg::vst_cmd_t op_q;
  logic [AW-1:0]     cnt_q;
  logic [AW-1:0]     cnt_d;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= VST_S_IDLE;
      op_q    <= vst_pkg::VST_CMD_IDLE;
      cnt_q   <= ZERO;
    end
    else
    begin
      state_q <= state_d;
      op_q    <= t.start ? t.cmd : op_q;
      cnt_q   <= cnt_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      VST_S_IDLE:
      begin
        cnt_d = ZERO;
        if (t.start)
          state_d = (t.cmd == vst_pkg::VST_CMD_INIT) ? VST_S_INIT : VST_S_ACC;
      end
      VST_S_ACC:
        state_d = VST_S_IDLE;
      VST_S_INIT:
      begin
        cnt_d = AW'(cnt_q + 1'b1);
        if (cnt_q == LAST)
          state_d = VST_S_IDLE;
      end
      default:
        state_d = VST_S_IDLE;
    endcase
  end

  assign t.busy    = (state_q != VST_S_IDLE);
  assign t.wr_en   = (state_q == VST_S_ACC) && (op_q == vst_pkg::VST_CMD_WRITE);
  assign t.rd_en   = (state_q == VST_S_ACC) && (op_q == vst_pkg::VST_CMD_READ);
  assign t.init_en = (state_q == VST_S_INIT);
  assign t.done    = (state_q == VST_S_ACC) ||
                     ((state_q == VST_S_INIT) && (cnt_q == LAST));
  assign t.addr    = t.init_en ? cnt_q : t.idx;

endmodule
`default_nettype wire

/* hw/vst_top.sv */
// vlan / service table access block with apb registers and lookup ports
`timescale 1ns/10ps
`default_nettype none
module vst_top (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [vst_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [vst_pkg::VID_W-1:0]    lk_vid,
  input  wire logic [vst_pkg::PORT_W-1:0]   physical_ingress_port,
  output logic      [vst_pkg::PORTS:0]      lk_vlan_member_bits,
  output logic                              lk_flag_a,
  output logic                              lk_drop,
  output logic                              lk_no_learn,
  output logic                              lk_private,
  input  wire logic [vst_pkg::SVC_W-1:0]    lk_service_index,
  output logic      [vst_pkg::PORTS-1:0]    lk_service_dest_bits,
  output logic      [vst_pkg::SPAN_W-1:0]   lk_service_spanning_instance,
  output logic                              lk_service_egress_key_flag,
  output logic      [vst_pkg::POL_W-1:0]    lk_service_policer_index,
  input  wire logic [vst_pkg::PROF_W-1:0]   lk_profile,
  input  wire logic                         entry_backbone_domain_flag,
  input  wire logic                         lk_learn_req,
  output logic                              lk_port_domain_select,
  output logic                              lk_entry_is_backbone,
  output logic                              lk_domain_match,
  output logic                              lk_learn_ok
);

  //////////////////////////////////////////////////////////////////////////

  vst_tbl_if #(.AW(vst_pkg::VID_W)) vif ();
  vst_tbl_if #(.AW(vst_pkg::SVC_W)) sif ();

  vst_tbl_seq #(.AW(vst_pkg::VID_W)) u_vseq (
    .clk (clk),
    .rst (rst),
    .t   (vif)
  );

  vst_tbl_seq #(.AW(vst_pkg::SVC_W)) u_sseq (
    .clk (clk),
    .rst (rst),
    .t   (sif)
  );

  //////////////////////////////////////////////////////////////////////////
  // register state
  // the record registers double as the read buffers of both tables

  logic [vst_pkg::VID_W-1:0]  vidx_q;
  vst_pkg::vst_vlan_t         vrec_q;
  vst_pkg::vst_cmd_t          vcmd_q;
  logic [vst_pkg::SVC_W-1:0]  sidx_q;
  vst_pkg::vst_svc_t          srec_q;
  vst_pkg::vst_cmd_t          scmd_q;
  logic [vst_pkg::PROF_N-1:0] dom_q;
  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;

  //////////////////////////////////////////////////////////////////////////
  // apb decode

  logic hit_vidx;
  logic hit_vacc;
  logic hit_sidx;
  logic hit_sacc;
  logic hit_dom;
  logic hit_any;
  logic setup;
  logic apb_wr;
  logic vfree;
  logic sfree;

  assign hit_vidx = (paddr == vst_pkg::OFS_VLAN_IDX);
  assign hit_vacc = (paddr == vst_pkg::OFS_VLAN_ACC);
  assign hit_sidx = (paddr == vst_pkg::OFS_SVC_IDX);
  assign hit_sacc = (paddr == vst_pkg::OFS_SVC_ACC);
  assign hit_dom  = (paddr == vst_pkg::OFS_DOMAIN);
  assign hit_any  = hit_vidx | hit_vacc | hit_sidx | hit_sacc | hit_dom;
  assign setup    = psel & ~penable;
  // writes land at the access edge, the one at which pready is high
  assign apb_wr   = psel & penable & pwrite & pready_q & hit_any;

  // a table is writable only while its command field shows idle; this keeps
  // the index and record stable under an operation in flight
  assign vfree = (vcmd_q == vst_pkg::VST_CMD_IDLE);
  assign sfree = (scmd_q == vst_pkg::VST_CMD_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // vlan table

  vst_pkg::vst_vlan_t vtab_q [vst_pkg::VLAN_N];
  vst_pkg::vst_vlan_t vrd;
  vst_pkg::vst_vlan_t vlk;
  vst_pkg::vst_vlan_t vwr_d;

  assign vif.start = ~vfree & ~vif.busy;
  assign vif.cmd   = vcmd_q;
  assign vif.idx   = vidx_q;
  assign vrd       = vtab_q[vif.addr];
  assign vlk       = vtab_q[lk_vid];
  assign vwr_d     = vif.init_en ? vst_pkg::VLAN_DEF : vrec_q;

  // init loads the default into every entry on each cycle of the walk; the
  // walk itself only paces the return to idle, as a real sweep would
  for (genvar i = 0; i < vst_pkg::VLAN_N; i++)
  begin : g_vlan
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        vtab_q[i] <= vst_pkg::VLAN_DEF;
      else if (vif.init_en ||
               (vif.wr_en && vif.addr == vst_pkg::VID_W'(i)))
        vtab_q[i] <= vwr_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vidx_q <= '0;
      vrec_q <= '0;
    end
    else if (vif.rd_en)
      vrec_q <= vrd;
    else if (apb_wr && vfree && hit_vidx)
    begin
      vidx_q          <= pwdata[vst_pkg::VIDX_LSB +: vst_pkg::VID_W];
      vrec_q.mirror   <= pwdata[vst_pkg::VMIR_BIT];
      vrec_q.filt     <= pwdata[vst_pkg::VFILT_BIT];
      vrec_q.no_learn <= pwdata[vst_pkg::VNOLR_BIT];
      vrec_q.priv     <= pwdata[vst_pkg::VPRIV_BIT];
    end
    else if (apb_wr && vfree && hit_vacc)
      vrec_q.members <= pwdata[vst_pkg::MASK_LSB +: vst_pkg::PORTS];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      vcmd_q <= vst_pkg::VST_CMD_IDLE;
    else if (vif.done)
      vcmd_q <= vst_pkg::VST_CMD_IDLE;
    else if (apb_wr && vfree && hit_vacc)
      vcmd_q <= vst_pkg::vst_cmd_t'(pwdata[vst_pkg::CMD_LSB +: vst_pkg::CMD_W]);
  end

  //////////////////////////////////////////////////////////////////////////
  // service table

  vst_pkg::vst_svc_t stab_q [vst_pkg::SVC_N];
  vst_pkg::vst_svc_t srd;
  vst_pkg::vst_svc_t slk;
  vst_pkg::vst_svc_t swr_d;

  assign sif.start = ~sfree & ~sif.busy;
  assign sif.cmd   = scmd_q;
  assign sif.idx   = sidx_q;
  assign srd       = stab_q[sif.addr];
  assign slk       = stab_q[lk_service_index];
  assign swr_d     = sif.init_en ? vst_pkg::SVC_DEF : srec_q;

  for (genvar j = 0; j < vst_pkg::SVC_N; j++)
  begin : g_svc
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        stab_q[j] <= vst_pkg::SVC_DEF;
      else if (sif.init_en ||
               (sif.wr_en && sif.addr == vst_pkg::SVC_W'(j)))
        stab_q[j] <= swr_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sidx_q <= '0;
      srec_q <= '0;
    end
    else if (sif.rd_en)
      srec_q <= srd;
    else if (apb_wr && sfree && hit_sidx)
    begin
      sidx_q      <= pwdata[vst_pkg::SIDX_LSB +: vst_pkg::SVC_W];
      srec_q.span <= pwdata[vst_pkg::SSPAN_LSB +: vst_pkg::SPAN_W];
      srec_q.key  <= pwdata[vst_pkg::SKEY_BIT];
      srec_q.pol  <= pwdata[vst_pkg::SPOL_LSB +: vst_pkg::POL_W];
    end
    else if (apb_wr && sfree && hit_sacc)
      srec_q.dest <= pwdata[vst_pkg::MASK_LSB +: vst_pkg::PORTS];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      scmd_q <= vst_pkg::VST_CMD_IDLE;
    else if (sif.done)
      scmd_q <= vst_pkg::VST_CMD_IDLE;
    else if (apb_wr && sfree && hit_sacc)
      scmd_q <= vst_pkg::vst_cmd_t'(pwdata[vst_pkg::CMD_LSB +: vst_pkg::CMD_W]);
  end

  //////////////////////////////////////////////////////////////////////////
  // domain select per profile

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dom_q <= '0;
    else if (apb_wr && hit_dom)
      dom_q <= pwdata[vst_pkg::PROF_N-1:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux and bus answer; zero wait states, unmapped gives pslverr

  logic [31:0] rd_vidx;
  logic [31:0] rd_vacc;
  logic [31:0] rd_sidx;
  logic [31:0] rd_sacc;
  logic [31:0] rd_mux;

  assign rd_vidx = {16'h0000, vrec_q.priv, vrec_q.no_learn, vrec_q.filt,
                    vrec_q.mirror, vidx_q};
  assign rd_vacc = {19'h00000, vrec_q.members, vcmd_q};
  assign rd_sidx = {9'h000, srec_q.pol, srec_q.key, srec_q.span, sidx_q};
  assign rd_sacc = {19'h00000, srec_q.dest, scmd_q};
  assign rd_mux  = hit_vidx ? rd_vidx :
                   hit_vacc ? rd_vacc :
                   hit_sidx ? rd_sidx :
                   hit_sacc ? rd_sacc :
                   hit_dom  ? {16'h0000, dom_q} : 32'h00000000;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= setup ? rd_mux : prdata_q;
      pready_q  <= setup;
      pslverr_q <= setup & ~hit_any;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////
  // lookup side, one cycle latency

  logic [15:0] mem_ext;
  logic        dom_sel;

  // processor port sits one above the front ports and always reads as member
  // ports 12 to 15 land in the zero padding and so count as non-members
  assign mem_ext = {4'h0, 1'b1, vlk.members};
  assign dom_sel = dom_q[lk_profile];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lk_vlan_member_bits          <= '0;
      lk_flag_a                    <= 1'b0;
      lk_drop                      <= 1'b0;
      lk_no_learn                  <= 1'b0;
      lk_private                   <= 1'b0;
      lk_service_dest_bits         <= '0;
      lk_service_spanning_instance <= '0;
      lk_service_egress_key_flag   <= 1'b0;
      lk_service_policer_index     <= '0;
      lk_port_domain_select        <= 1'b0;
      lk_entry_is_backbone         <= 1'b0;
      lk_domain_match              <= 1'b0;
      lk_learn_ok                  <= 1'b0;
    end
    else
    begin
      lk_vlan_member_bits          <= mem_ext[vst_pkg::PORTS:0];
      lk_flag_a                    <= vlk.mirror;
      lk_drop                      <= vlk.filt &
                                      ~mem_ext[physical_ingress_port];
      lk_no_learn                  <= vlk.no_learn;
      lk_private                   <= vlk.priv;
      lk_service_dest_bits         <= slk.dest;
      lk_service_spanning_instance <= slk.span;
      lk_service_egress_key_flag   <= slk.key;
      lk_service_policer_index     <= slk.pol;
      lk_port_domain_select        <= dom_sel;
      lk_entry_is_backbone         <= entry_backbone_domain_flag;
      lk_domain_match              <= dom_sel ==
                                      entry_backbone_domain_flag;
      lk_learn_ok                  <= lk_learn_req &&
                                      (dom_sel ==
                                       entry_backbone_domain_flag);
    end
  end

endmodule
`default_nettype wire

/* tb/vst_top_properties.sv */
// checker: port-level timing and lookup relations of the table block
`timescale 1ns/10ps
`default_nettype none
module vst_top_properties (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [vst_pkg::ADDR_W-1:0]   paddr,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [vst_pkg::PORT_W-1:0]   physical_ingress_port,
  input wire logic [vst_pkg::PORTS:0]      lk_vlan_member_bits,
  input wire logic                         lk_drop,
  input wire logic                         entry_backbone_domain_flag,
  input wire logic                         lk_learn_req,
  input wire logic                         lk_port_domain_select,
  input wire logic                         lk_entry_is_backbone,
  input wire logic                         lk_domain_match,
  input wire logic                         lk_learn_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_cpu_member;
    !$past(rst) |-> lk_vlan_member_bits[vst_pkg::PORTS];
  endproperty
  a_cpu_member: assert property (p_cpu_member)
    else $error("processor port missing from membership");
  // a port outside the stored mask is the only cause of a drop
  property p_drop;
    (lk_drop && $past(physical_ingress_port) <= 4'hb)
      |-> !lk_vlan_member_bits[$past(physical_ingress_port)];
  endproperty
  a_drop: assert property (p_drop)
    else $error("drop raised for a member port");
  property p_match;
    !$past(rst) |->
      lk_domain_match == (lk_port_domain_select == lk_entry_is_backbone);
  endproperty
  a_match: assert property (p_match)
    else $error("domain match disagrees with select and entry flag");
  property p_entry;
    !$past(rst) |-> lk_entry_is_backbone == $past(entry_backbone_domain_flag);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry domain flag not passed through");
  property p_learn;
    !$past(rst) |-> lk_learn_ok == ($past(lk_learn_req) && lk_domain_match);
  endproperty
  a_learn: assert property (p_learn)
    else $error("learn allowed outside own domain");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup)
    else $error("no pready after setup");
  property p_err_map;
    psel && !penable && paddr <= 12'h010 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("error on a mapped register");
  c_drop: cover property (lk_drop);
  c_learn: cover property (lk_learn_ok);
  c_err: cover property (pslverr);
endmodule
bind vst_top vst_top_properties i_props (.clk(clk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .physical_ingress_port(physical_ingress_port),
  .lk_vlan_member_bits(lk_vlan_member_bits), .lk_drop(lk_drop),
  .entry_backbone_domain_flag(entry_backbone_domain_flag),
  .lk_learn_req(lk_learn_req), .lk_port_domain_select(lk_port_domain_select),
  .lk_entry_is_backbone(lk_entry_is_backbone),
  .lk_domain_match(lk_domain_match), .lk_learn_ok(lk_learn_ok));
`default_nettype wire

/* tb/vst_top_bench.sv */
// testbench: apb table commands, lookups and domain select
`timescale 1ns/10ps
`default_nettype none
module vst_top_bench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr, lk_vid, lk_vlan_member_bits;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  physical_ingress_port, lk_profile;
  logic        lk_flag_a, lk_drop, lk_no_learn, lk_private;
  logic [7:0]  lk_service_index, lk_service_policer_index;
  logic [10:0] lk_service_dest_bits;
  logic [5:0]  lk_service_spanning_instance;
  logic        lk_service_egress_key_flag, entry_backbone_domain_flag;
  logic        lk_learn_req, lk_port_domain_select, lk_entry_is_backbone;
  logic        lk_domain_match, lk_learn_ok;
  int          n_fail, comparisons;

  vst_top i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lk_vid(lk_vid),
    .physical_ingress_port(physical_ingress_port),
    .lk_vlan_member_bits(lk_vlan_member_bits), .lk_flag_a(lk_flag_a),
    .lk_drop(lk_drop), .lk_no_learn(lk_no_learn), .lk_private(lk_private),
    .lk_service_index(lk_service_index),
    .lk_service_dest_bits(lk_service_dest_bits),
    .lk_service_spanning_instance(lk_service_spanning_instance),
    .lk_service_egress_key_flag(lk_service_egress_key_flag),
    .lk_service_policer_index(lk_service_policer_index),
    .lk_profile(lk_profile),
    .entry_backbone_domain_flag(entry_backbone_domain_flag),
    .lk_learn_req(lk_learn_req),
    .lk_port_domain_select(lk_port_domain_select),
    .lk_entry_is_backbone(lk_entry_is_backbone),
    .lk_domain_match(lk_domain_match), .lk_learn_ok(lk_learn_ok));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string       n,
                     input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer; read data and error land in rdata and rerr
  // no cycle limit of its own: only the watchdog ends a hung access
  task automatic apb(input logic        w,
                     input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue a command word, then poll the same register until idle
  task automatic tcmd(input logic [11:0] a, input logic [31:0] d);
    int k;
    apb(1'b1, a, d);
    k = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      k++;
    end
    while (rdata[1:0] !== 2'h0 && k < 3000);
    chk("cmd idle", 32'h0, {30'h0, rdata[1:0]});
  endtask

  // lookups are registered: inputs land on one edge, outputs on the next
  task automatic vchk(input logic [11:0] m, input logic [3:0] f);
    repeat (2) @(posedge clk);
    chk("members", m, lk_vlan_member_bits);
    chk("vlan flags", f, {lk_drop, lk_private, lk_no_learn, lk_flag_a});
  endtask

  task automatic schk(input logic [25:0] r);
    repeat (2) @(posedge clk);
    chk("service", r, {lk_service_dest_bits, lk_service_spanning_instance,
      lk_service_egress_key_flag, lk_service_policer_index});
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    lk_vid <= 12'h123;
    lk_service_index <= 8'h42;
    physical_ingress_port <= 4'h5;
    vchk(12'hfff, 4'h0);
    schk({11'h7ff, 15'h0});
    apb(1'b0, 12'h010, 32'h0);
    chk("domain reset", 32'h0, rdata);
  endtask

  task automatic t_vlan;
    apb(1'b1, 12'h000, {16'h0, 4'hf, 12'hfff});
    tcmd(12'h004, {19'h0, 11'h2a5, 2'h2});
    apb(1'b1, 12'h000, 32'h0000_0fff);
    tcmd(12'h004, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("vlan idx", {16'h0, 4'hf, 12'hfff}, rdata);
    apb(1'b0, 12'h004, 32'h0);
    chk("vlan acc", {19'h0, 11'h2a5, 2'h0}, rdata);
    lk_vid <= 12'hfff;
    physical_ingress_port <= 4'h1;
    vchk({1'b1, 11'h2a5}, 4'hf);
    physical_ingress_port <= 4'h0;
    vchk({1'b1, 11'h2a5}, 4'h7);
    physical_ingress_port <= 4'hb;
    vchk({1'b1, 11'h2a5}, 4'h7);
    lk_vid <= 12'h000;
    vchk(12'hfff, 4'h0);
    // write command issued mid-init must be dropped
    apb(1'b1, 12'h004, 32'h3);
    tcmd(12'h004, {19'h0, 11'h7fe, 2'h2});
    apb(1'b0, 12'h004, 32'h0);
    chk("vlan acc busy", 32'h0, rdata);
    lk_vid <= 12'hfff;
    physical_ingress_port <= 4'h1;
    vchk(12'hfff, 4'h0);
  endtask

  task automatic t_svc;
    apb(1'b1, 12'h008, {9'h0, 8'ha5, 1'b1, 6'h3f, 8'hff});
    tcmd(12'h00c, {19'h0, 11'h155, 2'h2});
    apb(1'b1, 12'h008, 32'h0000_00ff);
    tcmd(12'h00c, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("svc idx", {9'h0, 8'ha5, 1'b1, 6'h3f, 8'hff}, rdata);
    apb(1'b0, 12'h00c, 32'h0);
    chk("svc acc", {19'h0, 11'h155, 2'h0}, rdata);
    lk_service_index <= 8'hff;
    schk({11'h155, 6'h3f, 1'b1, 8'ha5});
    lk_service_index <= 8'h00;
    schk({11'h7ff, 15'h0});
    tcmd(12'h00c, 32'h3);
    lk_service_index <= 8'hff;
    schk({11'h7ff, 15'h0});
  endtask

  task automatic t_domain;
    int   ps[3] = '{0, 1, 15};
    logic s;
    apb(1'b1, 12'h010, 32'h0000_8001);
    apb(1'b0, 12'h010, 32'h0);
    chk("domain reg", 32'h0000_8001, rdata);
    for (int i = 0; i < 6; i++)
    begin
      s = (ps[i/2] != 1);
      lk_profile <= ps[i/2][3:0];
      entry_backbone_domain_flag <= i[0];
      lk_learn_req <= i[0];
      repeat (2) @(posedge clk);
      chk("domain", {s, i[0], s == i[0], i[0] && s}, {lk_port_domain_select,
        lk_entry_is_backbone, lk_domain_match, lk_learn_ok});
    end
  endtask

  task automatic t_unmapped;
    apb(1'b1, 12'h014, 32'hffff_ffff);
    chk("wr err", 32'h1, {31'h0, rerr});
    apb(1'b0, 12'h014, 32'h0);
    chk("rd err", 32'h1, {31'h0, rerr});
    chk("rd data", 32'h0, rdata);
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lk_vid, physical_ingress_port, lk_service_index} = '0;
    {lk_profile, entry_backbone_domain_flag, lk_learn_req} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_vlan();
    t_svc();
    t_domain();
    t_unmapped();
    tally_and_finish();
  end

  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
